// >>> core/tmr_async_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_async_timer
  import tmr_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [AW-1:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_CYC_IN,
  output logic WB_ACK_OUT,
  input wire logic SLOW_OSC_INPUT_IN,
  input wire logic CRYSTAL_IN_PIN_IN,
  input wire logic SYS_CLK_RC_IN,
  input wire logic [1:0] SLEEP_MODE_IN,
  output logic OSC_ENABLE_OUT,
  output logic EXT_CLOCK_BUFFER_ENABLE_OUT,
  output logic COMPARE_A_OUTPUT_PIN_OUT,
  output logic COMPARE_FLAG_OUT,
  output logic OVERFLOW_FLAG_OUT,
  output logic WAKE_OUT,
  output logic CPU_STALL_OUT
);
  tmr_wb_req_s req;
  tmr_pin_s pins [NPIN];
  tmr_sleep_e sleep_mode;
  logic ack_r;
  logic [31:0] dat_r;
  logic take;
  logic wr_any;
  logic [NREG-1:0] wr_reg;
  logic [DW-1:0] rdata;
  logic ext_clock_input_enable_r;
  logic async_clock_select_r;
  logic [NREG-1:0] busy_r;
  logic [DW-1:0] shadow_r [NREG];
  logic [DW-1:0] live_r [NREG];
  logic [DW-1:0] counter_value_r;
  logic [DW-1:0] hold_r;
  logic block_r;
  logic tclk;
  logic running;
  logic cnt_tick;
  logic match;
  logic ovf;
  logic [1:0] evt_now;
  logic [1:0] pend_r;
  logic [1:0] launch;
  logic [1:0] pipe_r [FLAG_SYNC_CYCLES];
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [1:0] flags_r;
  logic armed_r;
  logic wake_r;
  logic wake_nxt;
  logic [2:0] stall_r;
  logic pin_r;
  logic awake;

  assign sleep_mode = tmr_sleep_e'(SLEEP_MODE_IN);
  assign awake = (sleep_mode == SLP_AWAKE);

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp = gp + 1) begin : g_pin
      tmr_pin_sync u_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .pin_in(gp == PIN_SLOW ? SLOW_OSC_INPUT_IN : CRYSTAL_IN_PIN_IN),
        .pin_out(pins[gp])
      );
    end
  endgenerate

  // Wishbone classic slave: one wait state, ack drops after one cycle
  assign req.adr = WB_ADR_IN;
  assign req.dat = WB_DAT_IN[DW-1:0];
  assign req.we = WB_WE_IN;
  assign req.sel0 = WB_SEL_IN[0];
  assign take = WB_CYC_IN && WB_STB_IN && !ack_r;
  assign wr_any = take && req.we && req.sel0;
  assign wr_reg[REG_CNT] = wr_any && (req.adr == ADR_COUNTER);
  assign wr_reg[REG_CMP] = wr_any && (req.adr == ADR_COMPARE);
  assign wr_reg[REG_CA] = wr_any && (req.adr == ADR_CTRL_A);
  assign wr_reg[REG_CB] = wr_any && (req.adr == ADR_CTRL_B);

  always_comb begin
    rdata = RST_VAL;
    unique case (req.adr)
      ADR_COUNTER: rdata = async_clock_select_r ? hold_r : counter_value_r;
      ADR_COMPARE: rdata = shadow_r[REG_CMP];
      ADR_CTRL_A: rdata = shadow_r[REG_CA];
      ADR_CTRL_B: rdata = shadow_r[REG_CB];
      ADR_STATUS: rdata = {1'b0, ext_clock_input_enable_r, async_clock_select_r,
                           busy_r[REG_CNT], busy_r[REG_CMP], 1'b0,
                           busy_r[REG_CA], busy_r[REG_CB]};
      ADR_FLAGS: rdata = {6'h00, flags_r};
      default: rdata = RST_VAL;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= take;
      if (take) begin
        dat_r <= {24'h00_0000, rdata};
      end
    end
  end

  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = dat_r;

  // Changing the select leaves timer registers as they stand; no repair
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ext_clock_input_enable_r <= 1'b0;
      async_clock_select_r <= 1'b0;
    end else begin
      if (take && req.we && req.sel0 && req.adr == ADR_STATUS) begin
        ext_clock_input_enable_r <= req.dat[BIT_EXT];
        async_clock_select_r <= req.dat[BIT_AS] && SYS_CLK_RC_IN;
      end else if (!SYS_CLK_RC_IN) begin
        async_clock_select_r <= 1'b0;
      end
    end
  end

  // Timer clock edge: every cycle when synchronous, none in power-down, else a sampled pin rise
  always_comb begin
    if (!async_clock_select_r) begin
      tclk = 1'b1;
    end else if (sleep_mode == SLP_POWER_DOWN) begin
      tclk = 1'b0;
    end else if (ext_clock_input_enable_r) begin
      tclk = pins[PIN_EXT].rise;
    end else begin
      tclk = pins[PIN_SLOW].rise;
    end
  end

  assign running = (live_r[REG_CB][2:0] != CB_STOPPED);
  assign cnt_tick = tclk && running;

  assign OSC_ENABLE_OUT = async_clock_select_r && !ext_clock_input_enable_r
                          && (sleep_mode != SLP_POWER_DOWN);
  assign EXT_CLOCK_BUFFER_ENABLE_OUT = async_clock_select_r && ext_clock_input_enable_r
                                       && (sleep_mode != SLP_POWER_DOWN);

  // Software-side copies and busy flags; a new write wins over the clear
  genvar gr;
  generate
    for (gr = 0; gr < NREG; gr = gr + 1) begin : g_reg
      always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          shadow_r[gr] <= RST_VAL;
          busy_r[gr] <= 1'b0;
        end else begin
          if (wr_reg[gr]) begin
            shadow_r[gr] <= req.dat;
          end
          if (wr_reg[gr] && async_clock_select_r) begin
            busy_r[gr] <= 1'b1;
          end else if (tclk) begin
            busy_r[gr] <= 1'b0;
          end
        end
      end

      if (gr != REG_CNT) begin : g_live
        always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
          if (SYS_RST_IN) begin
            live_r[gr] <= RST_VAL;
          end else if (wr_reg[gr] && !async_clock_select_r) begin
            live_r[gr] <= req.dat;
          end else if (tclk && busy_r[gr]) begin
            live_r[gr] <= shadow_r[gr];
          end
        end
      end else begin : g_nolive
        assign live_r[gr] = counter_value_r;
      end
    end
  endgenerate

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      counter_value_r <= RST_VAL;
    end else if (wr_reg[REG_CNT] && !async_clock_select_r) begin
      counter_value_r <= req.dat;
    end else if (tclk && busy_r[REG_CNT]) begin
      counter_value_r <= shadow_r[REG_CNT];
    end else if (cnt_tick) begin
      counter_value_r <= counter_value_r + CNT_ONE;
    end
  end

  // A load marks the next timer edge as one without a match
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      block_r <= 1'b0;
    end else if ((wr_reg[REG_CNT] && !async_clock_select_r)
                 || (tclk && busy_r[REG_CNT])) begin
      block_r <= 1'b1;
    end else if (tclk) begin
      block_r <= 1'b0;
    end
  end

  // Frozen while asleep so the first read after wake shows the old value
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      hold_r <= RST_VAL;
    end else if (tclk && awake) begin
      hold_r <= counter_value_r;
    end
  end

  assign match = cnt_tick && !block_r
                 && (counter_value_r == live_r[REG_CMP]);
  assign ovf = cnt_tick && (counter_value_r == CNT_MAX);
  assign evt_now = {ovf, match};

  // Compare pin is driven from the timer edge, never from the flag path
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pin_r <= 1'b0;
    end else if (match && live_r[REG_CA][CA_TOGGLE]) begin
      pin_r <= !pin_r;
    end
  end
  assign COMPARE_A_OUTPUT_PIN_OUT = pin_r;

  // Event waits one timer edge, then crosses three processor cycles
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pend_r <= 2'b00;
    end else if (tclk) begin
      pend_r <= async_clock_select_r ? evt_now : 2'b00;
    end
  end
  assign launch = tclk ? pend_r : 2'b00;

  genvar gs;
  generate
    for (gs = 0; gs < FLAG_SYNC_CYCLES; gs = gs + 1) begin : g_pipe
      logic [1:0] pipe_src;
      if (gs == 0) begin : g_first
        assign pipe_src = launch;
      end else begin : g_next
        assign pipe_src = pipe_r[gs-1];
      end
      always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          pipe_r[gs] <= 2'b00;
        end else begin
          pipe_r[gs] <= pipe_src;
        end
      end
    end
  endgenerate

  assign flag_set = async_clock_select_r ? pipe_r[FLAG_SYNC_CYCLES-1] : evt_now;
  assign flag_clr = (take && req.we && req.sel0 && req.adr == ADR_FLAGS)
                    ? req.dat[1:0] : 2'b00;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      flags_r <= 2'b00;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end
  assign COMPARE_FLAG_OUT = flags_r[FLG_CMP];
  assign OVERFLOW_FLAG_OUT = flags_r[FLG_OVF];

  // Sleeping again before the re-arm edge loses the wake for that sleep
  assign wake_nxt = async_clock_select_r && armed_r && (launch != 2'b00)
                    && (sleep_mode == SLP_POWER_SAVE || sleep_mode == SLP_NOISE_RED);

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      armed_r <= 1'b1;
    end else if (wake_nxt) begin
      armed_r <= 1'b0;
    end else if (tclk && awake) begin
      armed_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wake_r <= 1'b0;
      stall_r <= 3'h0;
    end else begin
      wake_r <= wake_nxt;
      if (wake_nxt) begin
        stall_r <= STALL_CYCLES;
      end else if (stall_r != 3'h0) begin
        stall_r <= stall_r - 3'h1;
      end
    end
  end
  assign WAKE_OUT = wake_r;
  assign CPU_STALL_OUT = (stall_r != 3'h0);
endmodule
`default_nettype wire

// >>> core/tmr_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_sync
  import tmr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output var tmr_pin_s pin_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic rise_r;

  // Only s2 and s3 are looked at; s1 may be metastable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      rise_r <= (s2_r == s3_r) && s2_r && !level_r;
      if (s2_r == s3_r) begin
        level_r <= s2_r;
      end
    end
  end

  assign pin_out.level = level_r;
  assign pin_out.rise = rise_r;
endmodule
`default_nettype wire

// >>> core/tmr_pkg.sv
// Operation
// - Wake logic re-arms only after one timer cycle
// - Oscillator runs in async with external clock disabled, except power-down
// - Wake starts on timer cycle after event
// - Processor stalls four cycles after wake
// - Counter read via holding register, edge refreshed
// - Async flag transfer: one timer plus three cycles
// - Compare pin changes on timer clock only
// - Counter RW, reset zero, write blocks match
// - Compare register matched continuously against counter
// - External clock enable picks buffer over crystal
// - Async select chooses io clock or slow clock
// - Async select change may corrupt timer registers
// - Async select forced zero without RC clock
// - Counter busy flag set on write, cleared on load
// - Timer registers undefined after power-down wake
// - Status bit seven always reads zero
package tmr_pkg;
  localparam int DW = 8;
  localparam int AW = 8;
  localparam logic [AW-1:0] ADR_COUNTER = 8'h00;
  localparam logic [AW-1:0] ADR_COMPARE = 8'h04;
  localparam logic [AW-1:0] ADR_CTRL_A = 8'h08;
  localparam logic [AW-1:0] ADR_CTRL_B = 8'h0c;
  localparam logic [AW-1:0] ADR_STATUS = 8'h10;
  localparam logic [AW-1:0] ADR_FLAGS = 8'h14;
  localparam int REG_CNT = 0;
  localparam int REG_CMP = 1;
  localparam int REG_CA = 2;
  localparam int REG_CB = 3;
  localparam int NREG = 4;
  localparam int BIT_EXT = 6;
  localparam int BIT_AS = 5;
  localparam int FLG_CMP = 0;
  localparam int FLG_OVF = 1;
  localparam int CA_TOGGLE = 0;
  localparam logic [2:0] CB_STOPPED = 3'h0;
  localparam logic [DW-1:0] RST_VAL = 8'h00;
  localparam logic [DW-1:0] CNT_MAX = 8'hff;
  localparam logic [DW-1:0] CNT_ONE = 8'h01;
  localparam int FLAG_SYNC_CYCLES = 3;
  localparam logic [2:0] STALL_CYCLES = 3'h4;
  localparam int NPIN = 2;
  localparam int PIN_SLOW = 0;
  localparam int PIN_EXT = 1;

  typedef enum logic [1:0] {
    SLP_AWAKE = 2'b00,
    SLP_POWER_SAVE = 2'b01,
    SLP_POWER_DOWN = 2'b10,
    SLP_NOISE_RED = 2'b11
  } tmr_sleep_e;

  typedef struct packed {
    logic level;
    logic rise;
  } tmr_pin_s;

  typedef struct packed {
    logic [AW-1:0] adr;
    logic [DW-1:0] dat;
    logic we;
    logic sel0;
  } tmr_wb_req_s;
endpackage

// >>> testbench/test_async_timer0_sync_logic.sv
`timescale 1ns/1ps
`default_nettype none
module test_async_timer0_sync_logic;
  import tmr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic we = 1'b0;
  logic stb = 1'b0;
  logic cyc = 1'b0;
  logic slow = 1'b0;
  logic slow_run = 1'b0;
  logic xtal = 1'b0;
  logic xtal_run = 1'b0;
  logic rc = 1'b1;
  logic [1:0] slp = SLP_AWAKE;
  logic ack, osc_en, ext_en, pin, fcmp, fovf, wake, stall;
  logic [63:0] q[$];
  logic [63:0] qe;
  logic [31:0] v;
  int n_mismatch = 0;
  int n_checks = 0;
  int k;
  always #10 clk = ~clk;
  tmr_async_timer tmr_async_timer_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .WB_ADR_IN(adr),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_WE_IN(we), .WB_SEL_IN(4'hf), .WB_STB_IN(stb),
    .WB_CYC_IN(cyc), .WB_ACK_OUT(ack), .SLOW_OSC_INPUT_IN(slow), .CRYSTAL_IN_PIN_IN(xtal),
    .SYS_CLK_RC_IN(rc), .SLEEP_MODE_IN(slp), .OSC_ENABLE_OUT(osc_en),
    .EXT_CLOCK_BUFFER_ENABLE_OUT(ext_en), .COMPARE_A_OUTPUT_PIN_OUT(pin),
    .COMPARE_FLAG_OUT(fcmp), .OVERFLOW_FLAG_OUT(fovf), .WAKE_OUT(wake), .CPU_STALL_OUT(stall));
  // Slow crystal stands still until slow_run is set, after the busy-bit checks
  always begin
    repeat (10) @(posedge clk);
    if (slow_run) slow <= ~slow;
    if (xtal_run) xtal <= ~xtal;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Mask of zero turns a read into a poll that still checks bits 31:8 are zero
  task automatic bus(input logic [AW-1:0] a, input logic w, input logic [7:0] d,
                     input logic [7:0] m, input logic [7:0] e);
    int i = 0;
    adr <= a;
    we <= w;
    wdat <= {24'h0, d};
    cyc <= 1'b1;
    stb <= 1'b1;
    if (!w) q.push_back({24'hffffff, m, 24'h0, e});
    do begin
      @(posedge clk);
      i++;
    end while (!ack && i < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 50) begin
      n_mismatch++;
      close_out();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 8'h00, 8'h00);
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00, m, e);
  endtask
  task automatic settle();
    int j;
    for (j = 0; j < 40; j++) begin
      rd(ADR_STATUS, 8'h00, 8'h00);
      if (rdat[4:0] === 5'h0) break;
    end
    if (j == 40) begin
      n_mismatch++;
      close_out();
    end
  endtask
  always @(posedge clk) begin
    if (ack && !we && q.size() > 0) begin
      qe = q.pop_front();
      check(rdat & qe[63:32], qe[31:0], "read data");
    end
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(32'h80ef88a9));
    v = $urandom();
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADR_COUNTER, 8'hff, 8'h00);
    rd(ADR_COMPARE, 8'hff, 8'h00);
    rd(ADR_STATUS, 8'hff, 8'h00);
    wr(ADR_COMPARE, v[7:0]);
    wr(ADR_COUNTER, v[15:8]);
    wr(8'h20, v[23:16]);
    rd(ADR_COMPARE, 8'hff, v[7:0]);
    rd(ADR_COUNTER, 8'hff, v[15:8]);
    rd(8'h20, 8'hff, 8'h00);
    rc <= 1'b0;
    wr(ADR_STATUS, 8'h60);
    rd(ADR_STATUS, 8'hff, 8'h40);
    rc <= 1'b1;
    wr(ADR_STATUS, 8'h60);
    check(ext_en, 1'b1, "ext buffer");
    check(osc_en, 1'b0, "crystal osc");
    // External clock alone must drive the load while the slow crystal stands
    wr(ADR_CTRL_A, 8'h01);
    rd(ADR_STATUS, 8'hff, 8'h62);
    xtal_run <= 1'b1;
    settle();
    xtal_run <= 1'b0;
    slp <= SLP_POWER_DOWN;
    @(posedge clk);
    check(ext_en, 1'b0, "ext buffer");
    slp <= SLP_AWAKE;
    wr(ADR_STATUS, 8'h20);
    check(osc_en, 1'b1, "crystal osc");
    // Busy bits must show while the slow clock is still standing
    wr(ADR_COUNTER, 8'h33);
    rd(ADR_STATUS, 8'hff, 8'h30);
    wr(ADR_COMPARE, 8'h36);
    wr(ADR_CTRL_A, 8'h01);
    rd(ADR_STATUS, 8'hff, 8'h3a);
    // Model oscillator is stable from its first edge, so no settling wait
    slow_run <= 1'b1;
    settle();
    wr(ADR_CTRL_A, 8'h01);
    settle();
    rd(ADR_COUNTER, 8'hff, 8'h33);
    wr(ADR_CTRL_B, 8'h01);
    settle();
    slp <= SLP_POWER_SAVE;
    for (k = 0; k < 400 && !wake; k++) @(posedge clk);
    check(wake, 1'b1, "wake");
    check(fcmp, 1'b0, "compare flag early");
    check(pin, 1'b1, "compare pin");
    slp <= SLP_AWAKE;
    repeat (3) @(posedge clk);
    check(fcmp, 1'b1, "compare flag");
    rd(ADR_COUNTER, 8'hff, 8'h33);
    wr(ADR_FLAGS, 8'h01);
    rd(ADR_FLAGS, 8'h01, 8'h00);
    // A counter load equal to the compare value must not match on the next edge
    wr(ADR_COUNTER, 8'h36);
    settle();
    repeat (80) @(posedge clk);
    check(fcmp, 1'b0, "blocked match");
    check(pin, 1'b1, "blocked pin");
    wr(ADR_COUNTER, 8'hfe);
    settle();
    slp <= SLP_NOISE_RED;
    for (k = 0; k < 400 && !wake; k++) @(posedge clk);
    check(wake, 1'b1, "wake noise");
    check(stall, 1'b1, "stall");
    slp <= SLP_AWAKE;
    repeat (3) @(posedge clk);
    check(fovf, 1'b1, "overflow flag");
    check(stall, 1'b1, "stall end");
    @(posedge clk);
    check(stall, 1'b0, "stall over");
    rd(ADR_FLAGS, 8'h03, 8'h02);
    close_out();
  end
endmodule
`default_nettype wire

// >>> testbench/tmr_async_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_async_timer_chk
  import tmr_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [AW-1:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_WE_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_ACK_OUT,
  input wire logic SYS_CLK_RC_IN,
  input wire logic [1:0] SLEEP_MODE_IN,
  input wire logic OSC_ENABLE_OUT,
  input wire logic EXT_CLOCK_BUFFER_ENABLE_OUT,
  input wire logic COMPARE_FLAG_OUT,
  input wire logic WAKE_OUT,
  input wire logic CPU_STALL_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  property p_ack_next;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once;
    WB_ACK_OUT |=> !WB_ACK_OUT;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_stall_len;
    WAKE_OUT |-> CPU_STALL_OUT [*4] ##1 !CPU_STALL_OUT;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length");
  property p_wake_sleep;
    WAKE_OUT |-> $past(SLEEP_MODE_IN) inside {SLP_POWER_SAVE, SLP_NOISE_RED};
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
  property p_osc_pd;
    OSC_ENABLE_OUT || EXT_CLOCK_BUFFER_ENABLE_OUT |-> SLEEP_MODE_IN != SLP_POWER_DOWN;
  endproperty
  a_osc_pd: assert property (p_osc_pd) else $error("clock on in power-down");
  property p_ext_xor;
    !(OSC_ENABLE_OUT && EXT_CLOCK_BUFFER_ENABLE_OUT);
  endproperty
  a_ext_xor: assert property (p_ext_xor) else $error("both clock sources on");
  property p_rc;
    OSC_ENABLE_OUT || EXT_CLOCK_BUFFER_ENABLE_OUT |-> $past(SYS_CLK_RC_IN);
  endproperty
  a_rc: assert property (p_rc) else $error("async without rc clock");
  property p_rsv;
    WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == ADR_STATUS |-> WB_DAT_OUT[31:7] == 25'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("status top bit set");
  c_wake: cover property (WAKE_OUT);
  c_flag: cover property ($rose(COMPARE_FLAG_OUT));
  c_osc: cover property (OSC_ENABLE_OUT);
endmodule
bind tmr_async_timer tmr_async_timer_chk tmr_async_timer_chk_inst (.CLK_IN, .SYS_RST_IN,
  .WB_ADR_IN, .WB_DAT_OUT, .WB_WE_IN, .WB_STB_IN, .WB_CYC_IN, .WB_ACK_OUT, .SYS_CLK_RC_IN,
  .SLEEP_MODE_IN, .OSC_ENABLE_OUT, .EXT_CLOCK_BUFFER_ENABLE_OUT, .COMPARE_FLAG_OUT,
  .WAKE_OUT, .CPU_STALL_OUT);
`default_nettype wire
